// ---- rtl/load_group_pkg.sv ----
// shared constants and types for the 8-bit load group decoder
package load_group_pkg;
	localparam logic [7:0] PREFIX_FIRST = 8'hDD;
	localparam logic [7:0] PREFIX_SECOND = 8'hFD;
	localparam logic [7:0] OP_STORE_IMM = 8'h36;
	localparam logic [1:0] GRP_MOVE = 2'h1;
	localparam logic [1:0] GRP_IMM = 2'h0;
	localparam logic [2:0] FIELD_MEM = 3'h6;
	localparam logic [2:0] REG_A = 3'h7;
	localparam logic [2:0] REG_B = 3'h0;
	localparam logic [2:0] REG_C = 3'h1;
	localparam logic [2:0] REG_D = 3'h2;
	localparam logic [2:0] REG_E = 3'h3;
	localparam logic [2:0] REG_H = 3'h4;
	localparam logic [2:0] REG_L = 3'h5;
	// T states of each machine cycle kind
	localparam logic [2:0] T_FETCH = 3'h4;
	localparam logic [2:0] T_MEM = 3'h3;
	localparam logic [2:0] T_ADD = 3'h5;
	localparam real CLK_MHZ = 100.0;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [15:0] RESET_WORD = 16'h0000;

	typedef struct packed {
		logic [7:0] a;
		logic [7:0] f;
		logic [7:0] b;
		logic [7:0] c;
		logic [7:0] d;
		logic [7:0] e;
		logic [7:0] h;
		logic [7:0] l;
		logic [15:0] first_index_pointer;
		logic [15:0] second_index_pointer;
	} regfile_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [15:0] addr;
		logic [7:0] wdata;
	} mem_req_t;
endpackage : load_group_pkg

// ---- rtl/eight_bit_load_group_decode.sv ----
// decoder and executor for the 8-bit load group
// What this block does
// - register move, one machine cycle, 4 T
// - fields A=111 B..L=000..101 decoded
// - immediate load into register, 7 T
// - register loaded from pointer pair, 7 T
// - first index prefix load, 19 T
// - second index prefix load, 19 T
// - displacement signed, added to index pointer
// - register stored through pointer pair, 7 T
// - register stored at first index, 19 T
// - register stored at second index, 19 T
// - immediate stored through pointer pair, 10 T
// - machine cycles of listed T states each
`timescale 1ns/1ns
module eight_bit_load_group_decode (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic [7:0] i_mem_rdata,
	output load_group_pkg::mem_req_t o_mem,
	output load_group_pkg::regfile_t o_regs,
	output logic o_fetch,
	output logic o_done
);
	////////////////////////////////////////////////////////////////////
	// memory data synchronised; program bytes hold for a whole machine cycle
	logic [7:0] rd_s1_reg;
	logic [7:0] rd_s2_reg;

	typedef enum logic [5:0] {
		ST_FETCH = 6'b00_0001,
		ST_PFETCH = 6'b00_0010,
		ST_OPER = 6'b00_0100,
		ST_ADD = 6'b00_1000,
		ST_MEM = 6'b01_0000,
		ST_IMM2 = 6'b10_0000
	} state_t;

	state_t st_reg, st_next;
	logic [2:0] t_reg, t_next;
	logic [7:0] op_reg, op_next;
	logic [7:0] disp_reg, disp_next;
	logic [7:0] imm_reg, imm_next;
	logic [1:0] idx_reg, idx_next;
	logic [15:0] ea_reg, ea_next;
	logic [15:0] pc_reg, pc_next;
	load_group_pkg::regfile_t rf_reg, rf_next;
	load_group_pkg::mem_req_t mem_reg, mem_next;
	logic fetch_reg, fetch_next;
	logic done_reg, done_next;
	logic last_t;
	logic [7:0] byte_in;

	////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] get_reg(input load_group_pkg::regfile_t rf,
		input logic [2:0] sel);
		case (sel)
			load_group_pkg::REG_A: get_reg = rf.a;
			load_group_pkg::REG_B: get_reg = rf.b;
			load_group_pkg::REG_C: get_reg = rf.c;
			load_group_pkg::REG_D: get_reg = rf.d;
			load_group_pkg::REG_E: get_reg = rf.e;
			load_group_pkg::REG_H: get_reg = rf.h;
			load_group_pkg::REG_L: get_reg = rf.l;
			default: get_reg = load_group_pkg::RESET_BYTE;
		endcase
	endfunction : get_reg

	// field 110 never writes a register, flags never touched
	function automatic load_group_pkg::regfile_t put_reg(input load_group_pkg::regfile_t rf,
		input logic [2:0] sel, input logic [7:0] v);
		load_group_pkg::regfile_t r;
		r = rf;
		case (sel)
			load_group_pkg::REG_A: r.a = v;
			load_group_pkg::REG_B: r.b = v;
			load_group_pkg::REG_C: r.c = v;
			load_group_pkg::REG_D: r.d = v;
			load_group_pkg::REG_E: r.e = v;
			load_group_pkg::REG_H: r.h = v;
			load_group_pkg::REG_L: r.l = v;
			default: r = rf;
		endcase
		put_reg = r;
	endfunction : put_reg

	function automatic logic [15:0] index_addr(input logic [15:0] base,
		input logic [7:0] d);
		index_addr = base + {{8{d[7]}}, d};
	endfunction : index_addr

	assign byte_in = rd_s2_reg;

	////////////////////////////////////////////////////////////////////
	always_comb begin
		st_next = st_reg;
		t_next = t_reg + 3'h1;
		op_next = op_reg;
		disp_next = disp_reg;
		imm_next = imm_reg;
		idx_next = idx_reg;
		ea_next = ea_reg;
		pc_next = pc_reg;
		rf_next = rf_reg;
		mem_next = mem_reg;
		fetch_next = 1'b0;
		done_next = 1'b0;
		last_t = 1'b0;
		case (st_reg)
			ST_FETCH: begin
				last_t = (t_reg == load_group_pkg::T_FETCH);
				if (last_t) begin
					t_next = 3'h1;
					pc_next = pc_reg + 16'h0001;
					fetch_next = 1'b1;
					op_next = byte_in;
					if (byte_in == load_group_pkg::PREFIX_FIRST
						|| byte_in == load_group_pkg::PREFIX_SECOND) begin
						idx_next = (byte_in == load_group_pkg::PREFIX_FIRST) ? 2'h1 : 2'h2;
						st_next = ST_PFETCH;
					end else if (byte_in[7:6] == load_group_pkg::GRP_MOVE
						&& byte_in[5:3] != load_group_pkg::FIELD_MEM
						&& byte_in[2:0] != load_group_pkg::FIELD_MEM) begin
						rf_next = put_reg(rf_reg, byte_in[5:3],
							get_reg(rf_reg, byte_in[2:0]));
						done_next = 1'b1;
					end else if (byte_in[7:6] == load_group_pkg::GRP_MOVE
						&& (byte_in[5:3] == load_group_pkg::FIELD_MEM)
						!= (byte_in[2:0] == load_group_pkg::FIELD_MEM)) begin
						ea_next = {rf_reg.h, rf_reg.l};
						st_next = ST_MEM;
					end else if (byte_in == load_group_pkg::OP_STORE_IMM
						|| (byte_in[7:6] == load_group_pkg::GRP_IMM
						&& byte_in[2:0] == load_group_pkg::FIELD_MEM)) begin
						st_next = ST_OPER;
					end else begin
						done_next = 1'b1;
					end
				end
			end
			ST_PFETCH: begin
				last_t = (t_reg == load_group_pkg::T_FETCH);
				if (last_t) begin
					t_next = 3'h1;
					pc_next = pc_reg + 16'h0001;
					fetch_next = 1'b1;
					op_next = byte_in;
					if (byte_in[7:6] == load_group_pkg::GRP_MOVE
						&& ((byte_in[5:3] == load_group_pkg::FIELD_MEM)
						!= (byte_in[2:0] == load_group_pkg::FIELD_MEM))) begin
						st_next = ST_OPER;
					end else begin
						st_next = ST_FETCH;
						idx_next = 2'h0;
						done_next = 1'b1;
					end
				end
			end
			ST_OPER: begin
				last_t = (t_reg == load_group_pkg::T_MEM);
				if (last_t) begin
					t_next = 3'h1;
					pc_next = pc_reg + 16'h0001;
					if (idx_reg != 2'h0) begin
						disp_next = byte_in;
						st_next = ST_ADD;
					end else if (op_reg == load_group_pkg::OP_STORE_IMM) begin
						imm_next = byte_in;
						ea_next = {rf_reg.h, rf_reg.l};
						st_next = ST_MEM;
					end else begin
						rf_next = put_reg(rf_reg, op_reg[5:3], byte_in);
						st_next = ST_FETCH;
						done_next = 1'b1;
					end
				end
			end
			ST_ADD: begin // address add cycle of 5 T
				last_t = (t_reg == load_group_pkg::T_ADD);
				if (last_t) begin
					t_next = 3'h1;
					ea_next = index_addr((idx_reg == 2'h1) ? rf_reg.first_index_pointer
						: rf_reg.second_index_pointer,
						disp_reg);
					st_next = ST_MEM;
				end
			end
			ST_MEM: begin
				last_t = (t_reg == load_group_pkg::T_MEM);
				if (last_t) begin
					t_next = 3'h1;
					if (op_reg[5:3] != load_group_pkg::FIELD_MEM) begin
						rf_next = put_reg(rf_reg, op_reg[5:3], byte_in);
					end
					idx_next = 2'h0;
					st_next = ST_FETCH;
					done_next = 1'b1;
				end
			end
			default: begin
				st_next = ST_FETCH;
				t_next = 3'h1;
			end
		endcase
		// request for the coming T: data crosses two sync flops, so a read
		// must be on the bus from T1 to be usable at the last T of a 3 T cycle
		mem_next.rd = 1'b0;
		mem_next.wr = 1'b0;
		case (st_next)
			ST_FETCH, ST_PFETCH, ST_OPER: begin
				mem_next.rd = 1'b1;
				mem_next.addr = pc_next;
			end
			ST_MEM: begin
				mem_next.addr = ea_next;
				if (op_next[5:3] == load_group_pkg::FIELD_MEM) begin
					mem_next.wr = (t_next != load_group_pkg::T_MEM);
					mem_next.wdata = (op_next == load_group_pkg::OP_STORE_IMM) ? imm_next
						: get_reg(rf_next, op_next[2:0]);
				end else begin
					mem_next.rd = 1'b1;
				end
			end
			default: begin
				mem_next.addr = mem_reg.addr;
			end
		endcase
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			rd_s1_reg <= load_group_pkg::RESET_BYTE;
			rd_s2_reg <= load_group_pkg::RESET_BYTE;
			st_reg <= ST_FETCH;
			t_reg <= 3'h1;
			op_reg <= load_group_pkg::RESET_BYTE;
			disp_reg <= load_group_pkg::RESET_BYTE;
			imm_reg <= load_group_pkg::RESET_BYTE;
			idx_reg <= 2'h0;
			ea_reg <= load_group_pkg::RESET_WORD;
			pc_reg <= load_group_pkg::RESET_WORD;
			rf_reg <= '0;
			mem_reg <= '0;
			fetch_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			rd_s1_reg <= i_mem_rdata;
			rd_s2_reg <= rd_s1_reg;
			st_reg <= st_next;
			t_reg <= t_next;
			op_reg <= op_next;
			disp_reg <= disp_next;
			imm_reg <= imm_next;
			idx_reg <= idx_next;
			ea_reg <= ea_next;
			pc_reg <= pc_next;
			rf_reg <= rf_next;
			mem_reg <= mem_next;
			fetch_reg <= fetch_next;
			done_reg <= done_next;
		end
	end

	assign o_mem = mem_reg;
	assign o_regs = rf_reg;
	assign o_fetch = fetch_reg;
	assign o_done = done_reg;

	////////////////////////////////////////////////////////////////////
	chk_flags_stable: assert property (@(posedge i_mclk) disable iff (i_rst)
		$stable(rf_reg.f)) else $error("flag register changed");
	chk_move_four_t: assert property (@(posedge i_mclk) disable iff (i_rst)
		(st_reg == ST_FETCH && t_reg == 3'h1) |-> ##3 (st_reg == ST_FETCH
		&& t_reg == load_group_pkg::T_FETCH) ##1 (t_reg == 3'h1))
		else $error("move fetch not four T");
	chk_no_reg_110: assert property (@(posedge i_mclk) disable iff (i_rst)
		(st_reg == ST_MEM && op_reg[5:3] == load_group_pkg::FIELD_MEM)
		|-> (mem_reg.rd == 1'b0)) else $error("store cycle reads memory");
	sequence add_cycle;
		(st_reg == ST_ADD) [*5];
	endsequence
	chk_add_five_t: assert property (@(posedge i_mclk) disable iff (i_rst)
		(st_reg == ST_ADD && $changed(st_reg)) |-> add_cycle ##1 (st_reg == ST_MEM))
		else $error("add cycle not five T");
	chk_mem_three_t: assert property (@(posedge i_mclk) disable iff (i_rst)
		(st_reg == ST_MEM && $changed(st_reg)) |-> (st_reg == ST_MEM) [*3]
		##1 (st_reg == ST_FETCH)) else $error("memory cycle not three T");
	chk_first_index_addr: assert property (@(posedge i_mclk) disable iff (i_rst)
		(st_reg == ST_ADD && t_reg == load_group_pkg::T_ADD && idx_reg == 2'h1)
		|=> ea_reg == rf_reg.first_index_pointer + {{8{disp_reg[7]}}, disp_reg})
		else $error("first index address wrong");
	chk_second_index_addr: assert property (@(posedge i_mclk) disable iff (i_rst)
		(st_reg == ST_ADD && t_reg == load_group_pkg::T_ADD && idx_reg == 2'h2)
		|=> ea_reg == rf_reg.second_index_pointer + {{8{disp_reg[7]}}, disp_reg})
		else $error("second index address wrong");
	chk_pair_write: assert property (@(posedge i_mclk) disable iff (i_rst)
		(mem_reg.wr && idx_reg == 2'h0) |-> mem_reg.addr == {rf_reg.h, rf_reg.l})
		else $error("pointer pair store address wrong");
endmodule : eight_bit_load_group_decode

// ---- bench/mem_model.sv ----
// far-side memory model holding program and data bytes
`timescale 1ns/1ns
module mem_model (
	input wire logic i_mclk,
	input load_group_pkg::mem_req_t i_mem,
	output logic [7:0] o_rdata
);
	logic [7:0] mem [0:65535];
	initial o_rdata = 8'h00;
	// idle bus toggles so a stale byte never passes for fresh data
	always @(negedge i_mclk) o_rdata <= i_mem.rd ? mem[i_mem.addr] : ~o_rdata;
	always @(posedge i_mclk) if (i_mem.wr) mem[i_mem.addr] <= i_mem.wdata;
endmodule : mem_model

// ---- bench/tb_top.sv ----
// self-checking bench for the 8-bit load group decoder
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_top;
	logic i_mclk = 1'b0;
	logic i_rst = 1'b1;
	logic [7:0] rdata;
	logic fetch;
	logic done;
	load_group_pkg::mem_req_t mem_bus;
	load_group_pkg::regfile_t regs;
	int fail_count = 0;
	int n_checks = 0;
	int seed = 32'h0000_5209;
	int cyc = 0;
	int last = -1;
	int pc = 0;
	int nf = 0;
	logic [7:0] r [0:7];
	logic [7:0] rm [0:65535];
	int q_t[$];
	int q_f[$];
	int q_wa[$];
	logic [7:0] q_wd[$];
	load_group_pkg::regfile_t q_r[$];

	eight_bit_load_group_decode uut (.i_mclk(i_mclk), .i_rst(i_rst), .i_mem_rdata(rdata),
		.o_mem(mem_bus), .o_regs(regs), .o_fetch(fetch), .o_done(done));
	mem_model far (.i_mclk(i_mclk), .i_mem(mem_bus), .o_rdata(rdata));

	initial forever #5 i_mclk = ~i_mclk;

	function automatic int rnd(input int n);
		rnd = {$random(seed)} % n;
	endfunction : rnd

	task emit(input logic [7:0] b);
		far.mem[pc] = b;
		rm[pc] = b;
		pc++;
	endtask : emit

	task push(input int t, input int wa, input logic [7:0] wd, input int fe);
		q_t.push_back(t);
		q_f.push_back(fe);
		q_wa.push_back(wa);
		q_wd.push_back(wd);
		q_r.push_back(load_group_pkg::regfile_t'{a: r[7], f: 8'h00, b: r[0], c: r[1],
			d: r[2], e: r[3], h: r[4], l: r[5], first_index_pointer: 16'h0000,
			second_index_pointer: 16'h0000});
	endtask : push

	////////////////////////////////////////////////////////////
	// both index pointers stay zero, so only negative offsets keep stores off the program
	task gen(input int n);
		int k;
		int ds;
		int s;
		logic [7:0] v;
		logic [7:0] dp;
		logic [15:0] ptr;
		logic [7:0] mv;
		logic [7:0] rdop;
		for (int i = 0; i < n; i++) begin
			k = (i < 2) ? 0 : rnd(9);
			ds = (i < 2) ? 4 + i : rnd(5);
			if (ds == 4 && i > 1) ds = 7;
			s = rnd(7);
			if (s == 6) s = 7;
			v = 8'(rnd(256));
			if (i == 0) v = v | 8'h80;
			dp = 8'(rnd(256)) | 8'h80;
			ptr = {r[4], r[5]};
			mv = {load_group_pkg::GRP_MOVE, load_group_pkg::FIELD_MEM, s[2:0]};
			rdop = {load_group_pkg::GRP_MOVE, ds[2:0], load_group_pkg::FIELD_MEM};
			if (k == 5 || k == 6 || k == 8) begin
				emit(rnd(2) ? load_group_pkg::PREFIX_FIRST : load_group_pkg::PREFIX_SECOND);
			end
			case (k)
				0: begin
					emit({load_group_pkg::GRP_IMM, ds[2:0], load_group_pkg::FIELD_MEM});
					emit(v);
					r[ds] = v;
					push(7, -1, 8'h00, 1);
				end
				1: begin
					emit({load_group_pkg::GRP_MOVE, ds[2:0], s[2:0]});
					r[ds] = r[s];
					push(4, -1, 8'h00, 1);
				end
				2: begin
					emit(rdop);
					r[ds] = rm[ptr];
					push(7, -1, 8'h00, 1);
				end
				3: begin
					emit(mv);
					rm[ptr] = r[s];
					push(7, ptr, r[s], 1);
				end
				4: begin
					emit(load_group_pkg::OP_STORE_IMM);
					emit(v);
					rm[ptr] = v;
					push(10, ptr, v, 1);
				end
				5: begin
					emit(rdop);
					emit(dp);
					r[ds] = rm[{8'hFF, dp}];
					push(19, -1, 8'h00, 2);
				end
				6: begin
					emit(mv);
					emit(dp);
					rm[{8'hFF, dp}] = r[s];
					push(19, {8'hFF, dp}, r[s], 2);
				end
				8: begin
					// prefix then a foreign opcode: a no-op of two fetches
					emit(8'h00);
					push(8, -1, 8'h00, 2);
				end
				default: begin
					emit(8'h00);
					push(4, -1, 8'h00, 1);
				end
			endcase
		end
	endtask : gen

	task results();
		if (fail_count == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : results

	////////////////////////////////////////////////////////////
	always @(posedge i_mclk) cyc <= cyc + 1;

	always @(negedge i_mclk) begin
		if (fetch === 1'b1) nf++;
		if (done === 1'b1 && q_t.size() > 0) begin
			if (last >= 0) `CHK(cyc - last, q_t[0])
			last = cyc;
			`CHK(regs, q_r[0])
			`CHK(nf, q_f[0])
			nf = 0;
			if (q_wa[0] >= 0) `CHK(far.mem[q_wa[0]], q_wd[0])
			void'(q_t.pop_front());
			void'(q_f.pop_front());
			void'(q_r.pop_front());
			void'(q_wa.pop_front());
			void'(q_wd.pop_front());
		end
	end

	initial begin
		for (int a = 0; a < 65536; a++) begin
			far.mem[a] = 8'(rnd(256));
			rm[a] = far.mem[a];
		end
		for (int a = 0; a < 8; a++) r[a] = 8'h00;
		gen(80);
		repeat (4) @(negedge i_mclk);
		i_rst = 1'b0;
		while (q_t.size() > 0 && cyc < 5000) @(negedge i_mclk);
		if (q_t.size() > 0) fail_count++;
		results();
	end
endmodule : tb_top
